/* hw/aurs_rx.sv */
// Asynchronous serial receiver with two-deep FIFO, status and AHB-Lite registers
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Pending flag is high while receiver enabled and FIFO holds a character.
// - Pending flag ignores writes to it; only FIFO occupancy and receiver enable drive it.
// - Interrupt request needs receive, peripheral and global enables plus pending.
// - Pending flag follows occupancy whatever the interrupt enable bits are.
// - Every stored character keeps its own framing error bit.
// - Readable framing bit is the oldest character's, and read-only.
// - Framing error never stops reception; a pop advances data and status.
// - Port enable low resets port and clears framing; receive enable low keeps it.
// - Framing error alone raises no interrupt.
// - Third complete character while FIFO is full sets overrun.
// - During overrun stored characters stay readable; nothing new enters.
// - Clearing receive enable or port enable clears overrun.
// - Nine-bit mode shifts nine bits; ninth bit of oldest shown in status.
// - Address detect enable turns on address mode, only with nine-bit mode.
// - In address mode only ninth-bit-one characters enter the FIFO.
// - In address mode every delivered character shows ninth bit one.
// - Reading receive data pops the oldest character, exposing the next.
// - High line at start-bit middle aborts silently; low stop bit flags framing.
module aurs_rx
    import aurs_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rx_line,
    output logic             rx_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic        dph_wr_q;
    logic [7:0]  dph_addr_q;
    logic [31:0] hrdata_q;
    logic [7:0]  intctl_q;
    logic [7:0]  pie_q;
    logic [7:0]  rxctl_q;
    logic [7:0]  baud_q;
    logic [7:0]  portdir_q;
    logic [7:0]  txstat_q;

    wire        sel_ap   = hsel && htrans == HTRANS_NS && hready && ce;
    wire        rd_ap    = sel_ap && !hwrite;
    wire        wr_go    = dph_wr_q && ce;
    wire        wr_intc  = wr_go && dph_addr_q == OFF_INTCTL;
    wire        wr_pie   = wr_go && dph_addr_q == OFF_PIE;
    wire        wr_rxc   = wr_go && dph_addr_q == OFF_RXSTAT;
    wire        wr_baud  = wr_go && dph_addr_q == OFF_BAUD;
    wire        wr_pdir  = wr_go && dph_addr_q == OFF_PORTDIR;
    wire        wr_txs   = wr_go && dph_addr_q == OFF_TXSTAT;
    wire        wr_pir   = wr_go && dph_addr_q == OFF_PIR;
    wire [7:0]  wdat     = hwdata[7:0];

    wire        serial_port_enable     = rxctl_q[B_SERIAL_PORT_ENABLE];
    wire        continuous_receive_enable     = rxctl_q[B_CONTINUOUS_RECEIVE_ENABLE];
    wire        rx9      = rxctl_q[B_RX9];
    wire        rx_en    = serial_port_enable && continuous_receive_enable && !txstat_q[B_SYNC];
    wire        addr_md  = rxctl_q[B_ADDRESS_DETECT_ENABLE] && rx9;

    // No wait states; a low enable stretches the transfer instead of losing it
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_q   <= 1'b0;
            dph_addr_q <= 8'h00;
        end else if (ce && hready) begin
            dph_wr_q   <= hsel && htrans == HTRANS_NS && hwrite;
            dph_addr_q <= haddr[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            intctl_q  <= RST_INTCTL;
            pie_q     <= RST_PIE;
            rxctl_q   <= RST_RXCTL;
            baud_q    <= RST_BAUD;
            portdir_q <= RST_PORTDIR;
            txstat_q  <= RST_TXSTAT;
        end else begin
            if (wr_intc) intctl_q  <= wdat;
            if (wr_pie)  pie_q     <= wdat;
            if (wr_rxc)  rxctl_q   <= wdat & MSK_RXCTL;
            if (wr_baud) baud_q    <= wdat;
            if (wr_pdir) portdir_q <= wdat;
            if (wr_txs)  txstat_q  <= (wdat & MSK_TXSTAT) | RST_TXSTAT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oversample tick: 16x baud, low speed divides by four more

    logic [9:0] div_q;
    wire  [9:0] div_lim = txstat_q[B_BAUD_HIGH_SPEED_SELECT] ? {2'b00, baud_q} : {baud_q, LOWSPD_LO};
    wire        tick    = ce && div_q == div_lim;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 10'h000;
        end else if (ce) begin
            // New divisor restarts the timer so the new rate applies at once
            if (wr_baud || tick || !serial_port_enable) div_q <= 10'h000;
            else                          div_q <= div_q + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive shifter and framing

    aurs_state_t state_q;
    logic [3:0]  os_q;
    logic [3:0]  bit_q;
    logic [8:0]  shift_q;
    logic        rx_prev_q;

    wire       mid_pt    = tick && os_q == OVS_MID;
    wire       end_pt    = tick && os_q == OVS_LAST;
    wire [3:0] nbits     = rx9 ? BITS_9 : BITS_8;
    wire       char_done = state_q == ST_STOP && end_pt;
    wire [7:0] rx_data   = rx9 ? shift_q[7:0] : shift_q[8:1];
    wire       rx_ninth  = rx9 && shift_q[8];
    wire       accept    = !addr_md || rx_ninth;

    aurs_char_t new_char;
    // One assignment keeps the struct single-driven
    assign new_char = {!rx_line, rx_ninth, rx_data};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= ST_IDLE;
            os_q      <= 4'h0;
            bit_q     <= 4'h0;
            shift_q   <= 9'h000;
            rx_prev_q <= 1'b1;
        end else if (ce) begin
            rx_prev_q <= rx_line;
            if (tick) os_q <= os_q + 4'h1;
            if (!rx_en) begin
                state_q <= ST_IDLE;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                        if (rx_prev_q && !rx_line) begin
                            state_q <= ST_START;
                            os_q    <= 4'h0;
                        end
                    end
                    ST_START: begin
                        if (mid_pt) begin
                            // Restart the count so later samples fall mid-bit
                            os_q    <= 4'h0;
                            bit_q   <= 4'h0;
                            state_q <= rx_line ? ST_IDLE : ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (end_pt) begin
                            shift_q <= {rx_line, shift_q[8:1]};
                            bit_q   <= bit_q + 4'h1;
                            if (bit_q + 4'h1 == nbits) state_q <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        // Framing error still returns to hunting; nothing stalls
                        if (end_pt) state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-deep FIFO and overrun

    aurs_char_t fifo_q [2];
    logic       wp_q;
    logic       rp_q;
    logic [1:0] cnt_q;
    logic       overrun_error_q;

    wire        not_empty = cnt_q != 2'h0;
    wire        do_pop    = rd_ap && haddr[7:0] == OFF_RXDATA && not_empty;
    wire        push_req  = char_done && accept && rx_en;
    wire        full_now  = cnt_q == FIFO_FULL && !do_pop;
    wire        do_push   = push_req && !overrun_error_q && !full_now;
    aurs_char_t head;
    assign head = fifo_q[rp_q];

    generate
        for (genvar i = 0; i < 2; i++) begin : g_entry
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) fifo_q[i] <= '0;
                else if (ce && do_push && wp_q == 1'(i)) fifo_q[i] <= new_char;
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q   <= 1'b0;
            rp_q   <= 1'b0;
            cnt_q  <= 2'h0;
            overrun_error_q <= 1'b0;
        end else if (ce) begin
            if (!serial_port_enable) begin
                // Port disable flushes everything, framing status included
                wp_q   <= 1'b0;
                rp_q   <= 1'b0;
                cnt_q  <= 2'h0;
                overrun_error_q <= 1'b0;
            end else begin
                if (do_push) wp_q <= ~wp_q;
                if (do_pop)  rp_q <= ~rp_q;
                cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, do_pop};
                if (!continuous_receive_enable)                                   overrun_error_q <= 1'b0;
                else if (push_req && full_now && !overrun_error_q)    overrun_error_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status, interrupt request and read mux

    // Writes to the flag register are dropped: the flag has no storage
    wire       rx_pend  = rx_en && not_empty;
    wire       framing_error_st  = not_empty && head.framing_error;
    wire       ninth_st = not_empty && head.ninth;
    wire [7:0] pir_rd   = {2'b00, rx_pend, 5'b00000};
    wire [7:0] rxs_rd   = {rxctl_q[7:3], framing_error_st, overrun_error_q, ninth_st};
    wire [7:0] rd_mux   =
        haddr[7:0] == OFF_INTCTL  ? intctl_q  :
        haddr[7:0] == OFF_PIE     ? pie_q     :
        haddr[7:0] == OFF_PIR     ? pir_rd    :
        haddr[7:0] == OFF_RXDATA  ? head.data :
        haddr[7:0] == OFF_RXSTAT  ? rxs_rd    :
        haddr[7:0] == OFF_BAUD    ? baud_q    :
        haddr[7:0] == OFF_PORTDIR ? portdir_q :
        haddr[7:0] == OFF_TXSTAT  ? txstat_q  : 8'h00;

    // Framing status never feeds the request
    assign rx_irq = rx_pend && pie_q[B_RX_IRQ_ENABLE] && intctl_q[B_PERIPHERAL_IRQ_ENABLE]
                    && intctl_q[B_GIE];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)   hrdata_q <= 32'h0000_0000;
        else if (rd_ap) hrdata_q <= {24'h00_0000, rd_mux};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_pend;
        @(posedge hclk) disable iff (!hresetn)
        pir_rd[B_RCPF] == (serial_port_enable && continuous_receive_enable && !txstat_q[B_SYNC] && cnt_q != 2'h0);
    endproperty
    a_pend: assert property (p_pend) else $error("pending flag wrong");

    property p_pir_wr;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pir && ce && !do_push && !do_pop && !wr_rxc && !wr_txs) |=> $stable(rx_pend);
    endproperty
    a_pir_wr: assert property (p_pir_wr) else $error("write moved pending");

    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        rx_irq == (pir_rd[B_RCPF] && pie_q[B_RX_IRQ_ENABLE] && intctl_q[B_PERIPHERAL_IRQ_ENABLE] && intctl_q[B_GIE]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq gating wrong");

    property p_framing_error;
        @(posedge hclk) disable iff (!hresetn)
        (do_push && cnt_q == 2'h0) |=> rxs_rd[B_FRAMING_ERROR] == $past(new_char.framing_error);
    endproperty
    a_framing_error: assert property (p_framing_error) else $error("framing not head");

    property p_serial_port_enable;
        @(posedge hclk) disable iff (!hresetn)
        (!serial_port_enable && ce) |=> cnt_q == 2'h0 && !rxs_rd[B_FRAMING_ERROR] && !overrun_error_q;
    endproperty
    a_serial_port_enable: assert property (p_serial_port_enable) else $error("port disable no reset");

    property p_ovr;
        @(posedge hclk) disable iff (!hresetn)
        (ce && serial_port_enable && continuous_receive_enable && push_req && cnt_q == FIFO_FULL && !do_pop) |=> overrun_error_q;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun missed");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        (overrun_error_q && ce && !do_pop && serial_port_enable) |=> cnt_q == $past(cnt_q);
    endproperty
    a_hold: assert property (p_hold) else $error("char taken in overrun");

    property p_oclr;
        @(posedge hclk) disable iff (!hresetn)
        (!continuous_receive_enable && ce) |=> !overrun_error_q;
    endproperty
    a_oclr: assert property (p_oclr) else $error("overrun not cleared");

    property p_addr;
        @(posedge hclk) disable iff (!hresetn)
        (do_push && rxctl_q[B_ADDRESS_DETECT_ENABLE] && rx9) |-> shift_q[8];
    endproperty
    a_addr: assert property (p_addr) else $error("non-address stored");

    property p_pop;
        @(posedge hclk) disable iff (!hresetn)
        (do_pop && !do_push && serial_port_enable) |=> cnt_q == $past(cnt_q) - 2'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("pop failed");

    property p_abort;
        @(posedge hclk) disable iff (!hresetn)
        (state_q == ST_START && mid_pt && rx_line && rx_en) |=> state_q == ST_IDLE ##1
        !overrun_error_q || $past(overrun_error_q);
    endproperty
    a_abort: assert property (p_abort) else $error("start abort failed");

    c_push: cover property (@(posedge hclk) disable iff (!hresetn) do_push);
    c_ovr:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(overrun_error_q));
    c_framing_error: cover property (@(posedge hclk) disable iff (!hresetn) do_push && new_char.framing_error);

endmodule

`default_nettype wire

/* pkg/aurs_pkg.sv */
// Package with register map, field positions and timing constants of the receiver
package aurs_pkg;
    localparam logic [7:0] OFF_INTCTL  = 8'h00;
    localparam logic [7:0] OFF_PIE     = 8'h04;
    localparam logic [7:0] OFF_PIR     = 8'h08;
    localparam logic [7:0] OFF_RXDATA  = 8'h0C;
    localparam logic [7:0] OFF_RXSTAT  = 8'h10;
    localparam logic [7:0] OFF_BAUD    = 8'h14;
    localparam logic [7:0] OFF_PORTDIR = 8'h18;
    localparam logic [7:0] OFF_TXSTAT  = 8'h1C;

    localparam logic [7:0] RST_INTCTL  = 8'h00;
    localparam logic [7:0] RST_PIE     = 8'h00;
    localparam logic [7:0] RST_RXCTL   = 8'h00;
    localparam logic [7:0] RST_BAUD    = 8'h00;
    localparam logic [7:0] RST_PORTDIR = 8'hFF;
    localparam logic [7:0] RST_TXSTAT  = 8'h02;
    // Writable masks; other bits are status or unimplemented
    localparam logic [7:0] MSK_RXCTL   = 8'hF8;
    localparam logic [7:0] MSK_TXSTAT  = 8'hF5;

    localparam int B_GIE   = 7;
    localparam int B_PERIPHERAL_IRQ_ENABLE  = 6;
    localparam int B_RX_IRQ_ENABLE  = 5;
    localparam int B_RCPF  = 5;
    localparam int B_SERIAL_PORT_ENABLE  = 7;
    localparam int B_RX9   = 6;
    localparam int B_CONTINUOUS_RECEIVE_ENABLE  = 4;
    localparam int B_ADDRESS_DETECT_ENABLE = 3;
    localparam int B_FRAMING_ERROR  = 2;
    localparam int B_OVERRUN_ERROR  = 1;
    localparam int B_RECEIVED_NINTH_BIT  = 0;
    localparam int B_SYNC  = 4;
    localparam int B_BAUD_HIGH_SPEED_SELECT  = 2;

    localparam logic [3:0] OVS_MID   = 4'h7;
    localparam logic [3:0] OVS_LAST  = 4'hF;
    localparam logic [3:0] BITS_8    = 4'h8;
    localparam logic [3:0] BITS_9    = 4'h9;
    localparam logic [1:0] FIFO_FULL = 2'h2;
    localparam logic [1:0] LOWSPD_LO = 2'h3;
    localparam logic [1:0] HTRANS_NS = 2'h2;

    typedef struct packed {
        logic       framing_error;
        logic       ninth;
        logic [7:0] data;
    } aurs_char_t;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} aurs_state_t;
endpackage

/* dv/aurs_line_model.sv */
// Remote serial transmitter model driving the receive line
`timescale 1ns/100ps
`default_nettype none

module aurs_line_model (
    input  wire logic hclk,
    output logic      rx_line
);
    // Idle level is high; the line never floats outside frames
    initial rx_line = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    task automatic hold(input logic v, input int cyc);
        @(posedge hclk);
        rx_line <= v;
        repeat (cyc - 1) @(posedge hclk);
    endtask

    // Start bit, data LSB first, stop bit at given level, one idle bit
    task automatic send_char(input logic [8:0] d, input int nbits, input logic stop_lvl,
                             input int cyc);
        hold(1'b0, cyc);
        for (int i = 0; i < nbits; i++) hold(d[i], cyc);
        hold(stop_lvl, cyc);
        hold(1'b1, cyc);
    endtask

    // Short low pulse, gone before the start-bit middle
    task automatic glitch();
        hold(1'b0, 4);
        hold(1'b1, 48);
    endtask
endmodule

`default_nettype wire

/* dv/tb_aurs_rx.sv */
// Self-checking bench: register traffic and serial frames into the receiver
`timescale 1ns/100ps
`default_nettype none

module tb_aurs_rx
    import aurs_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        ce;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        rx_line;
    logic        rx_irq;
    int          fails;
    int          check_count;
    int          cycles;
    logic [7:0]  offs [10] = '{OFF_INTCTL, OFF_PIE, OFF_PIR, OFF_RXDATA, OFF_RXSTAT,
                               OFF_BAUD, OFF_PORTDIR, OFF_TXSTAT, 8'h20, 8'h24};
    logic [7:0]  rsts [10] = '{RST_INTCTL, RST_PIE, 8'h00, 8'h00, RST_RXCTL,
                               RST_BAUD, RST_PORTDIR, RST_TXSTAT, 8'h00, 8'h00};

    aurs_rx u_dut (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rx_line   (rx_line),
        .rx_irq    (rx_irq)
    );

    aurs_line_model u_line (
        .hclk    (hclk),
        .rx_line (rx_line)
    );

    always #20 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Generous ceiling; the whole sequence needs roughly 4400 cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails = fails + 1;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single word transfer; address phase held until hready is sampled high
    task automatic xfer(input logic [7:0] a, input logic wr_en, input logic [7:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= HTRANS_NS;
        hwrite <= wr_en;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        xfer(a, 1'b0, 8'h00, q);
        chk(q, {24'h000000, e});
    endtask

    task automatic tx(input logic [8:0] d, input int n, input logic stp, input int cyc);
        u_line.send_char(d, n, stp, cyc);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        fails = 0;
        check_count = 0;
        cycles = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk({31'h0, hresp}, 32'h0);
        for (int i = 0; i < 10; i++) rd_chk(offs[i], rsts[i]);
        wr(8'h20, 8'h55);
        rd_chk(8'h20, 8'h00);
        wr(OFF_PORTDIR, 8'h5A);
        rd_chk(OFF_PORTDIR, 8'h5A);
        // Fast bit time: high speed, divisor 0, sixteen clocks per bit
        wr(OFF_BAUD, 8'h00);
        wr(OFF_TXSTAT, 8'h04);
        rd_chk(OFF_TXSTAT, 8'h06);
        wr(OFF_RXSTAT, 8'h90);
        wr(OFF_PIR, 8'hFF);
        rd_chk(OFF_PIR, 8'h00);
        tx(9'h0A5, 8, 1'b1, 16);
        for (int i = 0; i < 8; i++) begin
            wr(OFF_INTCTL, {i[2], i[1], 6'h00});
            wr(OFF_PIE, {2'h0, i[0], 5'h00});
            @(negedge hclk);
            chk({31'h0, rx_irq}, {31'h0, &i[2:0]});
            rd_chk(OFF_PIR, 8'h20);
        end
        rd_chk(OFF_RXSTAT, 8'h90);
        // Clock enable low mid-request: the bus must stall, not lose or repeat the pop
        fork
            rd_chk(OFF_RXDATA, 8'hA5);
            begin
                @(posedge hclk);
                ce <= 1'b0;
                @(negedge hclk);
                chk({31'h0, hreadyout}, 32'h0);
                repeat (6) @(posedge hclk);
                ce <= 1'b1;
            end
        join
        rd_chk(OFF_PIR, 8'h00);
        chk({31'h0, rx_irq}, 32'h0);
        // Bad stop on first character, good on second
        tx(9'h03C, 8, 1'b0, 16);
        tx(9'h05A, 8, 1'b1, 16);
        rd_chk(OFF_RXSTAT, 8'h94);
        wr(OFF_RXSTAT, 8'h97);
        rd_chk(OFF_RXSTAT, 8'h94);
        rd_chk(OFF_RXDATA, 8'h3C);
        rd_chk(OFF_RXSTAT, 8'h90);
        rd_chk(OFF_RXDATA, 8'h5A);
        tx(9'h0FF, 8, 1'b0, 16);
        wr(OFF_RXSTAT, 8'h80);
        rd_chk(OFF_RXSTAT, 8'h84);
        rd_chk(OFF_PIR, 8'h00);
        wr(OFF_RXSTAT, 8'h00);
        rd_chk(OFF_RXSTAT, 8'h00);
        wr(OFF_RXSTAT, 8'h90);
        rd_chk(OFF_PIR, 8'h00);
        u_line.glitch();
        rd_chk(OFF_PIR, 8'h00);
        // Synchronous mode keeps the asynchronous receiver off
        wr(OFF_TXSTAT, 8'h14);
        tx(9'h099, 8, 1'b1, 16);
        wr(OFF_TXSTAT, 8'h04);
        rd_chk(OFF_PIR, 8'h00);
        // Third and fourth characters arrive with the FIFO full
        tx(9'h011, 8, 1'b1, 16);
        tx(9'h022, 8, 1'b1, 16);
        tx(9'h033, 8, 1'b1, 16);
        rd_chk(OFF_RXSTAT, 8'h92);
        tx(9'h044, 8, 1'b1, 16);
        rd_chk(OFF_RXDATA, 8'h11);
        rd_chk(OFF_RXDATA, 8'h22);
        rd_chk(OFF_PIR, 8'h00);
        rd_chk(OFF_RXSTAT, 8'h92);
        wr(OFF_RXSTAT, 8'h80);
        wr(OFF_RXSTAT, 8'h90);
        rd_chk(OFF_RXSTAT, 8'h90);
        tx(9'h055, 8, 1'b1, 16);
        rd_chk(OFF_RXDATA, 8'h55);
        // Nine-bit characters at a slower rate
        wr(OFF_BAUD, 8'h01);
        wr(OFF_RXSTAT, 8'hD0);
        tx(9'h1A5, 9, 1'b1, 32);
        tx(9'h0C3, 9, 1'b1, 32);
        rd_chk(OFF_RXSTAT, 8'hD1);
        rd_chk(OFF_RXDATA, 8'hA5);
        rd_chk(OFF_RXSTAT, 8'hD0);
        rd_chk(OFF_RXDATA, 8'hC3);
        wr(OFF_BAUD, 8'h00);
        wr(OFF_RXSTAT, 8'hD8);
        tx(9'h042, 9, 1'b1, 16);
        rd_chk(OFF_PIR, 8'h00);
        tx(9'h1F0, 9, 1'b1, 16);
        rd_chk(OFF_RXSTAT, 8'hD9);
        rd_chk(OFF_RXDATA, 8'hF0);
        wr(OFF_RXSTAT, 8'hD0);
        tx(9'h033, 9, 1'b1, 16);
        rd_chk(OFF_RXDATA, 8'h33);
        wr(OFF_RXSTAT, 8'hD8);
        tx(9'h066, 9, 1'b1, 16);
        rd_chk(OFF_PIR, 8'h00);
        // Address detect without nine-bit mode filters nothing; low speed
        wr(OFF_TXSTAT, 8'h00);
        wr(OFF_RXSTAT, 8'h98);
        tx(9'h077, 8, 1'b1, 64);
        rd_chk(OFF_RXDATA, 8'h77);
        final_report();
    end
endmodule

`default_nettype wire
